// ===== hw/icir_defs.svh
`ifndef ICIR_DEFS_SVH
`define ICIR_DEFS_SVH

// ****************************************************************
// register byte offsets within the block
// ****************************************************************
`define ICIR_OFS_CTRL       12'h100
`define ICIR_OFS_PMASK      12'h104
`define ICIR_OFS_BPOINT     12'h108
`define ICIR_OFS_ACK        12'h10C
`define ICIR_OFS_EOI        12'h110
`define ICIR_OFS_RUNPRIO    12'h114
`define ICIR_OFS_HIPEND     12'h118
`define ICIR_OFS_ABPOINT    12'h11C
`define ICIR_OFS_PID4       12'h1D0
`define ICIR_OFS_CID0       12'h1F0
`define ICIR_OFS_CID1       12'h1F4
`define ICIR_OFS_CID2       12'h1F8
`define ICIR_OFS_CID3       12'h1EC
`define ICIR_OFS_IIDR       12'h1FC

// ****************************************************************
// reset values
// ****************************************************************
`define ICIR_RST_CTRL       32'h0000_0000
`define ICIR_RST_PMASK      32'h0000_0000
`define ICIR_RST_BPOINT     32'h0000_0002
`define ICIR_RST_ABPOINT    32'h0000_0003
`define ICIR_RST_ACK        32'h0000_03FF
`define ICIR_RST_RUNPRIO    32'h0000_00FF
`define ICIR_RST_HIPEND     32'h0000_03FF

// ****************************************************************
// implemented bits of the writable registers and status views
// ****************************************************************
`define ICIR_MSK_CTRL       32'h0000_0003
`define ICIR_MSK_PMASK      32'h0000_00FF
`define ICIR_MSK_BPOINT     32'h0000_0007
`define ICIR_MSK_ID10       32'h0000_03FF
`define ICIR_MSK_BYTE       32'h0000_00FF

// ****************************************************************
// identification field positions (low bit of each field)
// ****************************************************************
`define ICIR_POS_PART       20
`define ICIR_POS_ARCH       16
`define ICIR_POS_REV        12
`define ICIR_POS_CONT       8
`define ICIR_POS_BLKS       4
`define ICIR_POS_CID3       24
`define ICIR_POS_CID2       16
`define ICIR_POS_CID1       8

// ****************************************************************
// bus encodings
// ****************************************************************
`define ICIR_HSIZE_WORD     3'h2
`define ICIR_ADDR_W         12

`endif

// ===== hw/icir_pkg.sv
package icir_pkg;

  // bus slave sequencing: wait for request, then one access cycle
  typedef enum logic {
    ICIR_ST_IDLE,
    ICIR_ST_ACCESS
  } icir_state_e;

  typedef logic [31:0] icir_word_t;

endpackage : icir_pkg

// ===== hw/icir_bus_if.sv
`timescale 1ns/1ps
// internal register access port between bus slave and register file
interface icir_bus_if;
  import icir_pkg::*;
  logic        wr;     // write strobe, one cycle
  logic        rd;     // read strobe, one cycle
  logic [11:0] addr;   // byte address
  icir_word_t  wdata;  // write data
  logic        word;   // full-word transfer
  logic        secure; // secure access
  icir_word_t  rdata;  // read data, combinational

  modport slave (output wr, rd, addr, wdata, word, secure,
                 input  rdata);
  modport regs  (input  wr, rd, addr, wdata, word, secure,
                 output rdata);
endinterface : icir_bus_if

// ===== hw/icir_ahb_slave.sv
`timescale 1ns/1ps
`include "icir_defs.svh"
module icir_ahb_slave
  import icir_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic        hsel_in,
  input  wire logic [11:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hnonsec_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  icir_bus_if.slave        bus
);

  // ****************************************************************
  // registered address phase
  // ****************************************************************
  icir_state_e state_r, state_nxt;  // slave sequencer
  logic        write_r, write_nxt;  // captured direction
  logic [11:0] addr_r,  addr_nxt;   // captured address
  logic        word_r,  word_nxt;   // captured size was a word
  logic        sec_r,   sec_nxt;    // captured secure attribute
  logic        rdy_r,   rdy_nxt;    // hreadyout flop
  icir_word_t  rdat_r,  rdat_nxt;   // hrdata flop
  logic        take;                // address phase accepted

  // a transfer is taken on NONSEQ or SEQ when the bus is ready
  assign take = hsel_in & htrans_in[1] & hready_in;

  // ****************************************************************
  // next state: every transfer costs one wait state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    write_nxt = write_r;
    addr_nxt  = addr_r;
    word_nxt  = word_r;
    sec_nxt   = sec_r;
    rdy_nxt   = rdy_r;
    rdat_nxt  = rdat_r;
    case (state_r)
      ICIR_ST_IDLE: begin
        if (take) begin
          // hold hready low while the register file answers
          state_nxt = ICIR_ST_ACCESS;
          write_nxt = hwrite_in;
          addr_nxt  = haddr_in;
          word_nxt  = (hsize_in == `ICIR_HSIZE_WORD);
          sec_nxt   = ~hnonsec_in;
          rdy_nxt   = 1'b0;
        end
      end
      ICIR_ST_ACCESS: begin
        // data phase ends next cycle with registered read data
        state_nxt = ICIR_ST_IDLE;
        rdy_nxt   = 1'b1;
        rdat_nxt  = write_r ? 32'h0000_0000 : bus.rdata;
      end
      default: begin
        state_nxt = ICIR_ST_IDLE;
        rdy_nxt   = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ICIR_ST_IDLE;
      write_r <= 1'b0;
      addr_r  <= 12'h000;
      word_r  <= 1'b0;
      sec_r   <= 1'b0;
      rdy_r   <= 1'b1;
      rdat_r  <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      write_r <= write_nxt;
      addr_r  <= addr_nxt;
      word_r  <= word_nxt;
      sec_r   <= sec_nxt;
      rdy_r   <= rdy_nxt;
      rdat_r  <= rdat_nxt;
    end
  end

  // strobes toward the register file during the access cycle
  assign bus.wr     = (state_r == ICIR_ST_ACCESS) & write_r;
  assign bus.rd     = (state_r == ICIR_ST_ACCESS) & ~write_r;
  assign bus.addr   = addr_r;
  assign bus.wdata  = hwdata_in;
  assign bus.word   = word_r;
  assign bus.secure = sec_r;

  assign hreadyout_out = rdy_r;
  assign hresp_out     = 1'b0;  // always OKAY
  assign hrdata_out    = rdat_r;

endmodule : icir_ahb_slave

// ===== hw/icir_regs.sv
// Function
// - id4 [7:4] gives log2 of 4KB blocks
// - id4 [3:0] gives continuation character count
// - component id is four bytes, id3 highest
// - id4 and component id registers constant, bits [31:8] zero
// - aliased binary point secure only, resets 0x3
// - control, mask reset 0; binary point 2
// - acknowledge, pending reset 3FF; running FF
// - end-of-interrupt write-only; registers 32 bits wide
// - implementer id read-only, four packed fields
// - implementer field: continuation, zero, 7-bit code
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "icir_defs.svh"
module icir_regs
  import icir_pkg::*;
#(
  parameter logic [3:0]  BLOCKS_LOG2   = 4'h0,     // 4KB blocks, log2
  parameter logic [3:0]  PERIPH_CONT   = 4'h0,     // arbitrary value
  parameter logic [31:0] COMPONENT_ID  = 32'hA5C3_5A3C, // arbitrary
  parameter logic [11:0] PART_NUMBER   = 12'h123,  // arbitrary value
  parameter logic [3:0]  ARCH_VERSION  = 4'h1,     // arbitrary value
  parameter logic [3:0]  REVISION      = 4'h0,     // arbitrary value
  parameter logic [3:0]  IMPL_CONT     = 4'h0,     // arbitrary value
  parameter logic [6:0]  IMPL_CODE     = 7'h2A     // arbitrary value
)(
  input  wire logic        mclk_in,        // 250 MHz system clock
  input  wire logic        resetn_in,      // async reset, active low
  input  wire logic        hsel_in,        // slave select
  input  wire logic [11:0] haddr_in,       // byte address
  input  wire logic [1:0]  htrans_in,      // transfer type
  input  wire logic        hwrite_in,      // write when high
  input  wire logic [2:0]  hsize_in,       // transfer size
  input  wire logic        hnonsec_in,     // non-secure access
  input  wire logic        hready_in,      // bus ready
  input  wire logic [31:0] hwdata_in,      // write data
  output logic             hreadyout_out,  // slave ready
  output logic             hresp_out,      // response, always OKAY
  output logic [31:0]      hrdata_out,     // read data
  input  wire logic [9:0]  ack_id_in,      // id for acknowledge
  input  wire logic [7:0]  run_prio_in,    // running priority
  input  wire logic [9:0]  pend_id_in,     // highest pending id
  output logic [1:0]       ctrl_out,       // interface control bits
  output logic [7:0]       prio_mask_out,  // priority mask
  output logic [2:0]       bpoint_out,     // binary point
  output logic [2:0]       abpoint_out,    // aliased binary point
  output logic             ack_read_out,   // acknowledge read pulse
  output logic             eoi_out,        // end-of-interrupt pulse
  output logic [9:0]       eoi_id_out      // id written with eoi
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // pad an eight-bit identification byte into a register word
  function automatic icir_word_t byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction : byte_word

  // keep only the implemented bits of a writable register
  function automatic icir_word_t keep(input icir_word_t v,
                                      input icir_word_t m);
    keep = v & m;
  endfunction : keep

  // ****************************************************************
  // constant identification words
  // ****************************************************************
  icir_word_t pid4_w;   // fourth peripheral id
  icir_word_t cid0_w;   // component id byte 0
  icir_word_t cid1_w;   // component id byte 1
  icir_word_t cid2_w;   // component id byte 2
  icir_word_t cid3_w;   // component id byte 3
  icir_word_t iidr_w;   // implementer identification
  logic [11:0] impl_w;  // implementer field

  // block count above, continuation count below
  assign pid4_w = byte_word({BLOCKS_LOG2,
                             PERIPH_CONT});

  // component id split low byte first, id3 carries [31:24]
  assign cid0_w = byte_word(COMPONENT_ID[`ICIR_POS_CID1-1:0]);
  assign cid1_w = byte_word(
    COMPONENT_ID[`ICIR_POS_CID2-1:`ICIR_POS_CID1]);
  assign cid2_w = byte_word(
    COMPONENT_ID[`ICIR_POS_CID3-1:`ICIR_POS_CID2]);
  assign cid3_w = byte_word(COMPONENT_ID[31:`ICIR_POS_CID3]);

  // continuation code, a fixed zero, then the 7-bit code
  assign impl_w = {IMPL_CONT, 1'b0, IMPL_CODE};

  // part, architecture, revision and implementer packed together
  assign iidr_w = {PART_NUMBER, ARCH_VERSION,
                   REVISION, impl_w};

  // ****************************************************************
  // bus slave
  // ****************************************************************
  icir_bus_if bus ();  // internal access port

  icir_ahb_slave u_slave (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hnonsec_in    (hnonsec_in),
    .hready_in     (hready_in),
    .hwdata_in     (hwdata_in),
    .hreadyout_out (hreadyout_out),
    .hresp_out     (hresp_out),
    .hrdata_out    (hrdata_out),
    .bus           (bus)
  );

  // ****************************************************************
  // writable and status state
  // ****************************************************************
  icir_word_t ctrl_r,    ctrl_nxt;     // interface control
  icir_word_t pmask_r,   pmask_nxt;    // priority mask
  icir_word_t bpoint_r,  bpoint_nxt;   // binary point
  icir_word_t abpoint_r, abpoint_nxt;  // aliased binary point
  icir_word_t ack_r,     ack_nxt;      // acknowledge view
  icir_word_t runprio_r, runprio_nxt;  // running priority view
  icir_word_t hipend_r,  hipend_nxt;   // highest pending view
  logic       ackrd_r,   ackrd_nxt;    // acknowledge read pulse
  logic       eoi_r,     eoi_nxt;      // end-of-interrupt pulse
  logic [9:0] eoiid_r,   eoiid_nxt;    // id written with eoi
  logic       wr_ok;                   // write that may take effect
  logic       rd_ok;                   // read that may return data
  logic       alias_ok;                // aliased register reachable

  // byte or halfword accesses have no defined effect: drop them
  assign wr_ok = bus.wr & bus.word;
  assign rd_ok = bus.rd & bus.word;

  // the aliased register answers secure accesses only
  assign alias_ok = bus.secure;

  // ****************************************************************
  // next-value logic for all software-visible state
  // ****************************************************************
  always_comb begin
    ctrl_nxt    = ctrl_r;
    pmask_nxt   = pmask_r;
    bpoint_nxt  = bpoint_r;
    abpoint_nxt = abpoint_r;
    // status views follow the interrupt core every cycle
    ack_nxt     = keep({22'h00_0000, ack_id_in}, `ICIR_MSK_ID10);
    runprio_nxt = keep({24'h00_0000, run_prio_in}, `ICIR_MSK_BYTE);
    hipend_nxt  = keep({22'h00_0000, pend_id_in}, `ICIR_MSK_ID10);
    ackrd_nxt   = 1'b0;
    eoi_nxt     = 1'b0;
    eoiid_nxt   = eoiid_r;
    if (wr_ok) begin
      case (bus.addr)
        `ICIR_OFS_CTRL: begin
          ctrl_nxt = keep(bus.wdata, `ICIR_MSK_CTRL);
        end
        `ICIR_OFS_PMASK: begin
          pmask_nxt = keep(bus.wdata, `ICIR_MSK_PMASK);
        end
        `ICIR_OFS_BPOINT: begin
          bpoint_nxt = keep(bus.wdata, `ICIR_MSK_BPOINT);
        end
        `ICIR_OFS_ABPOINT: begin
          // non-secure writes leave the register untouched
          if (alias_ok) begin
            abpoint_nxt = keep(bus.wdata, `ICIR_MSK_BPOINT);
          end
        end
        `ICIR_OFS_EOI: begin
          // write-only: only a pulse and the id leave the block
          eoi_nxt   = 1'b1;
          eoiid_nxt = bus.wdata[9:0];
        end
        default: begin
          // identification and status words ignore writes
          ctrl_nxt = ctrl_r;
        end
      endcase
    end
    // a read of the acknowledge word is signalled to the core
    if (rd_ok && (bus.addr == `ICIR_OFS_ACK)) begin
      ackrd_nxt = 1'b1;
    end
  end

  // ****************************************************************
  // state registers
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r    <= `ICIR_RST_CTRL;
      pmask_r   <= `ICIR_RST_PMASK;
      bpoint_r  <= `ICIR_RST_BPOINT;
      abpoint_r <= `ICIR_RST_ABPOINT;
      ack_r     <= `ICIR_RST_ACK;
      runprio_r <= `ICIR_RST_RUNPRIO;
      hipend_r  <= `ICIR_RST_HIPEND;
      ackrd_r   <= 1'b0;
      eoi_r     <= 1'b0;
      eoiid_r   <= 10'h000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      pmask_r   <= pmask_nxt;
      bpoint_r  <= bpoint_nxt;
      abpoint_r <= abpoint_nxt;
      ack_r     <= ack_nxt;
      runprio_r <= runprio_nxt;
      hipend_r  <= hipend_nxt;
      ackrd_r   <= ackrd_nxt;
      eoi_r     <= eoi_nxt;
      eoiid_r   <= eoiid_nxt;
    end
  end

  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  always_comb begin
    bus.rdata = 32'h0000_0000;
    if (rd_ok) begin
      case (bus.addr)
        `ICIR_OFS_CTRL:    bus.rdata = ctrl_r;
        `ICIR_OFS_PMASK:   bus.rdata = pmask_r;
        `ICIR_OFS_BPOINT:  bus.rdata = bpoint_r;
        `ICIR_OFS_ACK:     bus.rdata = ack_r;
        `ICIR_OFS_RUNPRIO: bus.rdata = runprio_r;
        `ICIR_OFS_HIPEND:  bus.rdata = hipend_r;
        `ICIR_OFS_ABPOINT: begin
          // non-secure reads of the alias see zero
          bus.rdata = alias_ok ? abpoint_r : 32'h0000_0000;
        end
        `ICIR_OFS_PID4:    bus.rdata = pid4_w;
        `ICIR_OFS_CID0:    bus.rdata = cid0_w;
        `ICIR_OFS_CID1:    bus.rdata = cid1_w;
        `ICIR_OFS_CID2:    bus.rdata = cid2_w;
        `ICIR_OFS_CID3:    bus.rdata = cid3_w;
        `ICIR_OFS_IIDR:    bus.rdata = iidr_w;
        default: begin
          // eoi, unmapped and reserved words read as zero
          bus.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // outputs, each from a flop
  // ****************************************************************
  assign ctrl_out      = ctrl_r[1:0];
  assign prio_mask_out = pmask_r[7:0];
  assign bpoint_out    = bpoint_r[2:0];
  assign abpoint_out   = abpoint_r[2:0];
  assign ack_read_out  = ackrd_r;
  assign eoi_out       = eoi_r;
  assign eoi_id_out    = eoiid_r;

endmodule : icir_regs

// ===== bench/icir_regs_chk.sv
`timescale 1ns/1ps
`include "icir_defs.svh"
// ****************************************************************
// protocol and register checker, sees the top ports only
// ****************************************************************
module icir_regs_chk
  import icir_pkg::*;
#(
  parameter logic [3:0]  BLOCKS_LOG2  = 4'h0,         // arbitrary value
  parameter logic [3:0]  PERIPH_CONT  = 4'h0,         // arbitrary value
  parameter logic [31:0] COMPONENT_ID = 32'h0000_0000, // arbitrary value
  parameter logic [11:0] PART_NUMBER  = 12'h000,      // arbitrary value
  parameter logic [3:0]  ARCH_VERSION = 4'h0,         // arbitrary value
  parameter logic [3:0]  REVISION     = 4'h0,         // arbitrary value
  parameter logic [3:0]  IMPL_CONT    = 4'h0,         // arbitrary value
  parameter logic [6:0]  IMPL_CODE    = 7'h00         // arbitrary value
)(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic        hsel_in,
  input  wire logic [11:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hnonsec_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic [31:0] hrdata_out,
  input  wire logic [7:0]  run_prio_in,
  input  wire logic [1:0]  ctrl_out,
  input  wire logic [7:0]  prio_mask_out,
  input  wire logic [2:0]  bpoint_out,
  input  wire logic [2:0]  abpoint_out,
  input  wire logic        ack_read_out,
  input  wire logic        eoi_out,
  input  wire logic [9:0]  eoi_id_out
);
  logic rd_w;  // word read taken at this edge
  logic wr_w;  // word write taken at this edge
  assign rd_w = hsel_in & htrans_in[1] & hready_in & ~hwrite_in &
                (hsize_in == `ICIR_HSIZE_WORD);
  assign wr_w = hsel_in & htrans_in[1] & hready_in & hwrite_in &
                (hsize_in == `ICIR_HSIZE_WORD);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ****************************************************************
  // assertions
  // ****************************************************************
  rst_vals_a: assert property ($rose(resetn_in) |-> ctrl_out == 2'h0 &&
    prio_mask_out == 8'h0 && bpoint_out == 3'h2 && abpoint_out == 3'h3)
    else $error("control registers wrong after reset");
  ctrl_write_a: assert property (wr_w && haddr_in == `ICIR_OFS_CTRL |->
    ##2 ctrl_out == 2'($past(hwdata_in))) else $error("control write lost");
  abp_secure_a: assert property (rd_w && hnonsec_in &&
    haddr_in == `ICIR_OFS_ABPOINT |-> ##2 hrdata_out == 32'h0)
    else $error("aliased binary point seen by non-secure read");
  eoi_pulse_a: assert property (wr_w && haddr_in == `ICIR_OFS_EOI |->
    ##2 eoi_out ##1 !eoi_out) else $error("end of irq pulse wrong");
  eoi_id_a: assert property (wr_w && haddr_in == `ICIR_OFS_EOI |->
    ##2 eoi_id_out == 10'($past(hwdata_in))) else $error("eoi id wrong");
  ack_pulse_a: assert property (rd_w && haddr_in == `ICIR_OFS_ACK |->
    ##2 ack_read_out ##1 !ack_read_out) else $error("ack pulse wrong");
  run_prio_a: assert property (rd_w && haddr_in == `ICIR_OFS_RUNPRIO |->
    ##2 hrdata_out == {24'h0, $past(run_prio_in, 2)})
    else $error("running priority read wrong");
  pid4_val_a: assert property (rd_w && haddr_in == `ICIR_OFS_PID4 |->
    ##2 hrdata_out == {24'h0, BLOCKS_LOG2, PERIPH_CONT})
    else $error("periph_ident_4 wrong");
  cid3_val_a: assert property (rd_w && haddr_in == `ICIR_OFS_CID3 |->
    ##2 hrdata_out == {24'h0, COMPONENT_ID[31:24]})
    else $error("component_ident_3 wrong");
  iidr_val_a: assert property (rd_w && haddr_in == `ICIR_OFS_IIDR |->
    ##2 hrdata_out == {PART_NUMBER, ARCH_VERSION, REVISION, IMPL_CONT,
    1'b0, IMPL_CODE}) else $error("implementer id wrong");
endmodule : icir_regs_chk

bind icir_regs icir_regs_chk #(.BLOCKS_LOG2(BLOCKS_LOG2),
  .PERIPH_CONT(PERIPH_CONT), .COMPONENT_ID(COMPONENT_ID),
  .PART_NUMBER(PART_NUMBER), .ARCH_VERSION(ARCH_VERSION),
  .REVISION(REVISION), .IMPL_CONT(IMPL_CONT), .IMPL_CODE(IMPL_CODE))
  icir_regs_chk_inst (.mclk_in, .resetn_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hsize_in, .hnonsec_in, .hready_in, .hwdata_in,
  .hrdata_out, .run_prio_in, .ctrl_out, .prio_mask_out, .bpoint_out,
  .abpoint_out, .ack_read_out, .eoi_out, .eoi_id_out);

// ===== bench/testbench.sv
`timescale 1ns/1ps
`include "icir_defs.svh"
module testbench;
  import icir_pkg::*;
  // identification values, all arbitrary
  localparam logic [3:0]  BLK = 4'h2;
  localparam logic [3:0]  PC  = 4'h3;
  localparam logic [31:0] CID = 32'h1C2D_3E4F;
  localparam logic [31:0] IID = {12'h5A6, 4'h2, 4'h1, 4'h4, 1'b0, 7'h55};
  localparam logic [11:0] ID_A [6] = '{`ICIR_OFS_PID4, `ICIR_OFS_CID0,
    `ICIR_OFS_CID1, `ICIR_OFS_CID2, `ICIR_OFS_CID3, `ICIR_OFS_IIDR};
  localparam logic [31:0] ID_V [6] = '{{24'h0, BLK, PC},
    {24'h0, CID[7:0]}, {24'h0, CID[15:8]}, {24'h0, CID[23:16]},
    {24'h0, CID[31:24]}, IID};
  localparam logic [31:0] RST_V [8] = '{`ICIR_RST_CTRL, `ICIR_RST_PMASK,
    `ICIR_RST_BPOINT, `ICIR_RST_ACK, 32'h0, `ICIR_RST_RUNPRIO,
    `ICIR_RST_HIPEND, `ICIR_RST_ABPOINT};
  localparam logic [11:0] RW_A [4] = '{`ICIR_OFS_CTRL, `ICIR_OFS_PMASK,
    `ICIR_OFS_BPOINT, `ICIR_OFS_ABPOINT};
  localparam logic [31:0] RW_M [4] = '{`ICIR_MSK_CTRL, `ICIR_MSK_PMASK,
    `ICIR_MSK_BPOINT, `ICIR_MSK_BPOINT};
  logic        mclk_in = 1'b0, resetn_in = 1'b0, hsel_in = 1'b0;
  logic [11:0] haddr_in = 12'h0;
  logic [1:0]  htrans_in = 2'h0;
  logic        hwrite_in = 1'b0, hnonsec_in = 1'b0;
  logic [2:0]  hsize_in = 3'h2;
  logic        hready_in;
  logic [31:0] hwdata_in = 32'h0, hrdata_out;
  logic        hreadyout_out, hresp_out, ack_read_out, eoi_out;
  logic [9:0]  ack_id_in = 10'h3FF, pend_id_in = 10'h3FF, eoi_id_out;
  logic [7:0]  run_prio_in = 8'hFF, prio_mask_out;
  logic [1:0]  ctrl_out;
  logic [2:0]  bpoint_out, abpoint_out;
  int          err_total = 0, checks = 0, cyc = 0, i, k;
  logic [31:0] seed = 32'haba9, d, rwe [4];
  icir_word_t  expq [$];     // expected read data, oldest first
  bit          rd_ph = 1'b0; // monitor: read data phase open
  assign hready_in = hreadyout_out;
  always #2 mclk_in = ~mclk_in;
  icir_regs #(.BLOCKS_LOG2(BLK), .PERIPH_CONT(PC), .COMPONENT_ID(CID),
    .PART_NUMBER(IID[31:20]), .ARCH_VERSION(IID[19:16]),
    .REVISION(IID[15:12]), .IMPL_CONT(IID[11:8]), .IMPL_CODE(IID[6:0]))
    icir_regs_inst (.mclk_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hnonsec_in, .hready_in, .hwdata_in,
    .hreadyout_out, .hresp_out, .hrdata_out, .ack_id_in, .run_prio_in,
    .pend_id_in, .ctrl_out, .prio_mask_out, .bpoint_out, .abpoint_out,
    .ack_read_out, .eoi_out, .eoi_id_out);
  // ****************************************************************
  // compare, verdict and bus tasks
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // one single transfer: address phase, then data phase
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] dat,
            input logic [2:0] sz, input logic ns);
    hsel_in <= 1'b1; htrans_in <= 2'h2; haddr_in <= a;
    hwrite_in <= wr; hsize_in <= sz; hnonsec_in <= ns;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    hsel_in <= 1'b0; htrans_in <= 2'h0; hwdata_in <= dat;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
  endtask : xfer
  task wr(input logic [11:0] a, input logic [31:0] dat, input logic ns);
    xfer(1'b1, a, dat, `ICIR_HSIZE_WORD, ns);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e, input logic ns);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0, `ICIR_HSIZE_WORD, ns);
  endtask : rd
  // read monitor: takes data at the edge that ends the data phase
  always @(posedge mclk_in) begin
    if (rd_ph && hreadyout_out) begin
      rd_ph = 1'b0;
      check({31'h0, hresp_out}, 32'h0);
      if (expq.size() == 0) check(hrdata_out, 32'hDEAD_0000);
      else check(hrdata_out, expq.pop_front());
    end
    if (hsel_in && htrans_in[1] && hready_in && !hwrite_in) rd_ph = 1'b1;
  end
  // hang guard
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    for (k = 0; k < 2; k++) begin
      repeat (5) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      check(32'(ctrl_out), 32'h0);
      check(32'(prio_mask_out), 32'h0);
      check(32'(bpoint_out), 32'h2);
      check(32'(abpoint_out), 32'h3);
      for (i = 0; i < 8; i++) begin
        if (i != 4) rd(12'h100 + 12'(4 * i), RST_V[i], 1'b0);
      end
      for (i = 0; i < 4; i++) begin
        d = $random(seed);
        rwe[i] = d & RW_M[i];
        wr(RW_A[i], d, 1'b0);
        rd(RW_A[i], rwe[i], 1'b0);
      end
      check(32'(prio_mask_out), rwe[1]);
      if (k == 0) resetn_in <= 1'b0; // second pass starts in reset
    end
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 6; i++) begin
        rd(ID_A[i], ID_V[i], k[0]);
        if (k == 0) wr(ID_A[i], 32'hFFFF_FFFF, 1'b0);
      end
    end
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      rwe[i] = d & RW_M[i];
      wr(RW_A[i], d, 1'b0);
    end
    check({30'h0, ctrl_out}, rwe[0]);
    check({29'h0, bpoint_out}, rwe[2]);
    xfer(1'b1, `ICIR_OFS_PMASK, ~rwe[1], 3'h0, 1'b0);
    expq.push_back(32'h0);
    xfer(1'b0, `ICIR_OFS_PMASK, 32'h0, 3'h1, 1'b0);
    rd(`ICIR_OFS_PMASK, rwe[1], 1'b0);
    wr(`ICIR_OFS_ABPOINT, ~rwe[3], 1'b1);
    rd(`ICIR_OFS_ABPOINT, 32'h0, 1'b1);
    rd(`ICIR_OFS_ABPOINT, rwe[3], 1'b0);
    check({29'h0, abpoint_out}, rwe[3]);
    for (i = 0; i < 3; i++) begin
      d = $random(seed);
      wr(`ICIR_OFS_EOI, d, 1'b0);
      check({22'h0, eoi_id_out}, {22'h0, d[9:0]});
      @(negedge mclk_in); // pulse has dropped after the closing edge
      check({31'h0, eoi_out}, 32'h0);
      @(posedge mclk_in);
      d = $random(seed);
      ack_id_in <= d[9:0];
      run_prio_in <= d[17:10];
      pend_id_in <= d[27:18];
      rd(`ICIR_OFS_ACK, {22'h0, d[9:0]}, 1'b0);
      wr(`ICIR_OFS_RUNPRIO, 32'hFFFF_FFFF, 1'b0);
      rd(`ICIR_OFS_RUNPRIO, {24'h0, d[17:10]}, 1'b0);
      rd(`ICIR_OFS_HIPEND, {22'h0, d[27:18]}, 1'b0);
    end
    wr(12'h040, 32'hFFFF_FFFF, 1'b0);
    rd(12'h040, 32'h0, 1'b0);
    repeat (3) @(posedge mclk_in);
    check(32'(expq.size()), 32'h0);
    summarize();
  end
endmodule : testbench
